// ===== src/ufa_pkg.sv
// package: constants for the user flash serial access port
package ufa_pkg;
  // ------------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W      = 9;
  localparam int DATA_W      = 16;
  localparam int WORDS       = 512;
  localparam int SECTOR_W    = 256;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // ring oscillator half period, in system clocks
  localparam int OSC_HALF_CYC  = 1;
  // divide ratio of the ring oscillator output
  localparam int OSC_DIV       = 4;
  // default sequence length in oscillator cycles
  localparam int PROG_OSC_CYC  = 40;
  localparam int ERASE_OSC_CYC = 200;
  // input synchroniser depth
  localparam int SYNC_STAGES   = 3;
endpackage

// ===== src/ufa_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ufa_sync #(
  parameter int W = 1
) (
  // clocking
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // signals
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, q_nxt;

  // first stage is read only by the second
  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    q_nxt  = q_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else if (ce) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// ===== src/ufa_port.sv
// user flash serial access port: array, registers, sequencer, oscillator
// How it works
// - 512 words of 16 bits, two sectors
// - clear erases whole sector chosen by MSB
// - shift select high: address shifts in serially
// - shift select low: address increments by one
// - address wraps to zero past top
// - address register is 9 bits wide
// - all operations use address register location
// - data shift: bit in, bit out
// - shift enters LSB, MSB goes out
// - data select low loads flash word
// - after load MSB is output first
// - strobe rising edge starts sequencer
// - busy high during sequence, low after
// - requests ignored while busy
// - divided clock is quarter oscillator rate
// - enable low holds divided clock high
// - oscillator runs when enabled or busy
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ufa_port #(
  parameter int PROG_CYC  = ufa_pkg::PROG_OSC_CYC,
  parameter int ERASE_CYC = ufa_pkg::ERASE_OSC_CYC
) (
  // clocking
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  // address register pins
  input  wire logic addr_shift_clock,
  input  wire logic addr_shift_sel,
  input  wire logic addr_serial_in,
  // data register pins
  input  wire logic data_reg_clock,
  input  wire logic data_shift_sel,
  input  wire logic data_serial_in,
  output logic      data_serial_out,
  // sequencer
  input  wire logic write_strobe,
  input  wire logic sector_clear_strobe,
  output logic      busy,
  // oscillator
  input  wire logic ring_clock_enable,
  output logic      divided_ring_clock,
  // live reprogramming status
  input  wire logic live_reprogram_request,
  output logic      live_reprogram_active
);
  localparam int AW = ufa_pkg::ADDR_W;
  localparam int DW = ufa_pkg::DATA_W;

  typedef enum logic [1:0] {UFA_IDLE, UFA_PROG, UFA_ERASE} ufa_state_t;

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [7:0] pin_raw, pin_s;
  assign pin_raw = {addr_shift_clock, addr_shift_sel, addr_serial_in, data_reg_clock,
                    data_shift_sel, data_serial_in, write_strobe, sector_clear_strobe};

  ufa_sync #(.W(8)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .d      (pin_raw),
    .q      (pin_s)
  );

  logic ack_s, asel_s, adin_s, dck_s, dsel_s, ddin_s, wr_s, clr_s;
  assign {ack_s, asel_s, adin_s, dck_s, dsel_s, ddin_s, wr_s, clr_s} = pin_s;

  // edge detectors work on filtered levels only
  logic ack_d_r, dck_d_r, wr_d_r, clr_d_r;
  logic ack_rise, dck_rise, wr_rise, clr_rise;
  assign ack_rise = ack_s & ~ack_d_r;
  assign dck_rise = dck_s & ~dck_d_r;
  assign wr_rise  = wr_s & ~wr_d_r;
  assign clr_rise = clr_s & ~clr_d_r;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  // array and sectors
  logic [DW-1:0] mem [ufa_pkg::WORDS] = '{default: ufa_pkg::ERASED_WORD}; // starts erased
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] data_r, data_nxt;
  ufa_state_t    st_r, st_nxt;
  logic [15:0]   cnt_r, cnt_nxt;
  logic [AW-1:0] op_addr_r, op_addr_nxt;
  logic [DW-1:0] op_data_r, op_data_nxt;
  logic [2:0]    osc_r, osc_nxt;
  logic          dclk_r, dclk_nxt;
  logic          osc_run;
  logic          osc_tick;
  logic          done;

  // oscillator runs while enabled or sequencing
  assign osc_run = ring_clock_enable | (st_r != UFA_IDLE);

  // ------------------------------------------------------------------
  // address and data registers
  // ------------------------------------------------------------------
  always_comb begin
    addr_nxt = addr_r;
    data_nxt = data_r;
    if (ack_rise && !live_reprogram_active) begin
      if (asel_s) begin
        addr_nxt = {addr_r[AW-2:0], adin_s};
      end else begin
        addr_nxt = addr_r + 9'h001;
      end
    end
    if (dck_rise && !live_reprogram_active) begin
      if (dsel_s) begin
        data_nxt = {data_r[DW-2:0], ddin_s};
      end else begin
        data_nxt = mem[addr_r];
      end
    end
  end

  assign data_serial_out = data_r[DW-1];

  // ------------------------------------------------------------------
  // oscillator and divider
  // ------------------------------------------------------------------
  // one tick per system clock; divide by four gives a quarter rate
  always_comb begin
    osc_nxt  = osc_r;
    dclk_nxt = dclk_r;
    osc_tick = 1'b0;
    if (osc_run) begin
      osc_tick = 1'b1;
      osc_nxt  = osc_r + 3'h1;
      if (osc_r[0]) begin
        dclk_nxt = ~dclk_r;
      end
    end
    if (!ring_clock_enable) begin
      dclk_nxt = 1'b1;
    end
  end

  assign divided_ring_clock = dclk_r;

  // ------------------------------------------------------------------
  // program / clear sequencer
  // ------------------------------------------------------------------
  assign done = (cnt_r == 16'h0001) && osc_tick && (st_r != UFA_IDLE);

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    op_addr_nxt = op_addr_r;
    op_data_nxt = op_data_r;
    case (st_r)
      UFA_IDLE: begin
        // strobes only take effect when idle
        if (!live_reprogram_active && wr_rise) begin
          st_nxt      = UFA_PROG;
          cnt_nxt     = 16'(PROG_CYC);
          op_addr_nxt = addr_r;
          op_data_nxt = data_r;
        end else if (!live_reprogram_active && clr_rise) begin
          st_nxt      = UFA_ERASE;
          cnt_nxt     = 16'(ERASE_CYC);
          op_addr_nxt = addr_r;
        end
      end
      UFA_PROG, UFA_ERASE: begin
        if (osc_tick) begin
          cnt_nxt = cnt_r - 16'h0001;
        end
        if (done) begin
          st_nxt = UFA_IDLE;
        end
      end
      default: st_nxt = UFA_IDLE;
    endcase
  end

  assign busy = (st_r != UFA_IDLE);
  assign live_reprogram_active = live_reprogram_request;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_r    <= '0;
      data_r    <= '0;
      st_r      <= UFA_IDLE;
      cnt_r     <= '0;
      op_addr_r <= '0;
      op_data_r <= '0;
      osc_r     <= '0;
      dclk_r    <= 1'b1;
      ack_d_r   <= 1'b0;
      dck_d_r   <= 1'b0;
      wr_d_r    <= 1'b0;
      clr_d_r   <= 1'b0;
    end else if (ce) begin
      addr_r    <= addr_nxt;
      data_r    <= data_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      op_addr_r <= op_addr_nxt;
      op_data_r <= op_data_nxt;
      osc_r     <= osc_nxt;
      dclk_r    <= dclk_nxt;
      ack_d_r   <= ack_s;
      dck_d_r   <= dck_s;
      wr_d_r    <= wr_s;
      clr_d_r   <= clr_s;
    end
  end

  // array write at end of sequence; programming only clears bits, clear sets the whole sector
  always_ff @(posedge clk) begin
    if (ce && done) begin
      if (st_r == UFA_PROG) begin
        mem[op_addr_r] <= mem[op_addr_r] & op_data_r;
      end else begin
        // whole sector selected by the msb
        for (int i = 0; i < ufa_pkg::SECTOR_W; i++) begin
          mem[{op_addr_r[AW-1], 8'(i)}] <= ufa_pkg::ERASED_WORD;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_busy_on_write: assert property (@(posedge clk) disable iff (!resetn)
    ce && !busy && wr_rise && !live_reprogram_active |=> busy) else $error("busy not raised");
  a_ignore_busy: assert property (@(posedge clk) disable iff (!resetn)
    ce && busy && !done |=> $stable(op_addr_r)) else $error("request taken while busy");
  a_addr_incr: assert property (@(posedge clk) disable iff (!resetn)
    ce && ack_rise && !asel_s && !live_reprogram_active |=> addr_r == $past(addr_r) + 9'h001)
    else $error("address not incremented");
  a_addr_shift: assert property (@(posedge clk) disable iff (!resetn)
    ce && ack_rise && asel_s && !live_reprogram_active |=> addr_r[0] == $past(adin_s))
    else $error("address shift wrong");
  a_data_shift: assert property (@(posedge clk) disable iff (!resetn)
    ce && dck_rise && dsel_s && !live_reprogram_active |=>
    data_serial_out == $past(data_r[DW-2])) else $error("data shift wrong");
  a_data_load: assert property (@(posedge clk) disable iff (!resetn)
    ce && dck_rise && !dsel_s && !live_reprogram_active && !done |=>
    data_r == mem[$past(addr_r)]) else $error("parallel load wrong");
  a_osc_high: assert property (@(posedge clk) disable iff (!resetn)
    ce && !ring_clock_enable |=> divided_ring_clock) else $error("divided clock not high");
  a_osc_div: assert property (@(posedge clk) disable iff (!resetn)
    ce && ring_clock_enable && busy && $rose(divided_ring_clock) |->
    ##2 (!ce || !divided_ring_clock || !ring_clock_enable)) else $error("divider rate wrong");

  // ------------------------------------------------------------------
  // sequencer and address checks
  // ------------------------------------------------------------------
  a_clear_busy: assert property (@(posedge clk) disable iff (!resetn)
    ce && !busy && clr_rise && !wr_rise && !live_reprogram_active |=> busy)
    else $error("busy not raised by clear");
  a_busy_done: assert property (@(posedge clk) disable iff (!resetn)
    ce && done |=> !busy)
    else $error("busy not dropped at end");
  a_busy_length: assert property (@(posedge clk) disable iff (!resetn)
    ce && busy && cnt_r > 16'h0001 |=> busy)
    else $error("sequence ended early");
  a_live_quiet: assert property (@(posedge clk) disable iff (!resetn)
    ce && !busy && live_reprogram_active |=> !busy)
    else $error("request taken during live reprogram");
  a_addr_wrap: assert property (@(posedge clk) disable iff (!resetn)
    ce && ack_rise && !asel_s && !live_reprogram_active && addr_r == 9'h1ff |=>
    addr_r == 9'h000) else $error("address did not wrap");
  a_prog_capture: assert property (@(posedge clk) disable iff (!resetn)
    ce && !busy && wr_rise && !live_reprogram_active |=>
    op_addr_r == $past(addr_r) && op_data_r == $past(data_r)) else $error("write not captured");
  a_erase_capture: assert property (@(posedge clk) disable iff (!resetn)
    ce && !busy && clr_rise && !wr_rise && !live_reprogram_active |=>
    st_r == UFA_ERASE && op_addr_r == $past(addr_r)) else $error("clear not captured");
endmodule
`default_nettype wire

// ===== test/ufa_ctl.sv
// controller model driving the flash port pins
`timescale 1ns/1ps
`default_nettype none
module ufa_ctl (
  // clocking
  input  wire logic clk,
  // address pins
  output var logic  addr_shift_clock,
  output var logic  addr_shift_sel,
  output var logic  addr_serial_in,
  // data pins
  output var logic  data_reg_clock,
  output var logic  data_shift_sel,
  output var logic  data_serial_in,
  input  wire logic data_serial_out,
  // sequencer and oscillator
  output var logic  write_strobe,
  output var logic  sector_clear_strobe,
  output var logic  ring_clock_enable
);
  // ------------------------------------------------------------------
  // pin tasks
  // ------------------------------------------------------------------
  // idle levels; link clocks stand low outside frames
  initial begin
    {addr_shift_clock, addr_shift_sel, addr_serial_in} = 3'h0;
    {data_reg_clock, data_shift_sel, data_serial_in} = 3'h0;
    {write_strobe, sector_clear_strobe, ring_clock_enable} = 3'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // 800 ns clock
  // data set at falling edge, so stable 4 clk around each rise
  task automatic pulse(input logic a);
    tick(4);
    if (a) addr_shift_clock <= 1'b1;
    else data_reg_clock <= 1'b1;
    tick(4);
    addr_shift_clock <= 1'b0;
    data_reg_clock <= 1'b0;
  endtask
  task automatic addr_load(input logic [8:0] a);
    addr_shift_sel <= 1'b1;
    for (int i = 8; i >= 0; i--) begin
      addr_serial_in <= a[i];
      pulse(1'b1);
    end
  endtask
  task automatic addr_inc;
    addr_shift_sel <= 1'b0;
    pulse(1'b1);
  endtask
  task automatic data_write(input logic [15:0] d);
    data_shift_sel <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      data_serial_in <= d[i];
      pulse(1'b0);
    end
  endtask
  // load, then 16 shift clocks, msb first
  task automatic data_read(output logic [15:0] q);
    data_shift_sel <= 1'b0;
    pulse(1'b0);
    tick(3);
    q[15] = data_serial_out;
    data_shift_sel <= 1'b1;
    for (int i = 14; i >= 0; i--) begin
      pulse(1'b0);
      tick(3);
      q[i] = data_serial_out;
    end
    // sixteenth shift clock completes the word
    pulse(1'b0);
  endtask
  task automatic strobe(input logic wr, input logic v);
    if (v) ring_clock_enable <= 1'b1;
    if (wr) write_strobe <= v;
    else sector_clear_strobe <= v;
  endtask
  task automatic osc(input logic v);
    ring_clock_enable <= v;
  endtask
endmodule
`default_nettype wire

// ===== test/user_flash_serial_access_port_tb_top.sv
// testbench for the user flash serial access port
`timescale 1ns/1ps
`default_nettype none
module user_flash_serial_access_port_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic live_reprogram_request = 1'b0;
  logic addr_shift_clock, addr_shift_sel, addr_serial_in, data_reg_clock;
  logic data_shift_sel, data_serial_in, data_serial_out, write_strobe;
  logic sector_clear_strobe, busy, ring_clock_enable, divided_ring_clock;
  logic live_reprogram_active;
  int   n_fail = 0;
  int   total_checks = 0;
  logic [15:0] q;
  always #50 clk = ~clk;
  // short sequences keep the run brief
  ufa_port #(.PROG_CYC(24), .ERASE_CYC(40)) DUT (.clk, .resetn, .ce,
    .addr_shift_clock, .addr_shift_sel, .addr_serial_in, .data_reg_clock,
    .data_shift_sel, .data_serial_in, .data_serial_out, .write_strobe,
    .sector_clear_strobe, .busy, .ring_clock_enable, .divided_ring_clock,
    .live_reprogram_request, .live_reprogram_active);
  ufa_ctl ctl (.clk, .addr_shift_clock, .addr_shift_sel, .addr_serial_in,
    .data_reg_clock, .data_shift_sel, .data_serial_in, .data_serial_out,
    .write_strobe, .sector_clear_strobe, .ring_clock_enable);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // strobe, time busy, optionally re-strobe while busy
  task automatic run_seq(input logic wr, input int len, input logic again);
    int n;
    n = 0;
    ctl.strobe(wr, 1'b1);
    while (busy !== 1'b1 && n < 12) begin
      @(posedge clk);
      n++;
    end
    chk(16'(busy), 16'h0001);
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
      if (again && n == 2) ctl.strobe(wr, 1'b0);
      if (again && n == 6) ctl.strobe(wr, 1'b1);
    end
    chk(16'(n), 16'(len));
    ctl.strobe(wr, 1'b0);
    ctl.tick(8);
    chk(16'(busy), 16'h0000);
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    ctl.addr_load(a);
    ctl.data_read(q);
    chk(q, exp);
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_osc;
    int   n;
    logic prev;
    n = 0;
    ctl.osc(1'b0);
    ctl.tick(4);
    repeat (12) begin
      @(negedge clk);
      n += int'(divided_ring_clock === 1'b1);
    end
    chk(16'(n), 16'h000c);
    n = 0;
    @(posedge clk);
    ctl.osc(1'b1);
    ctl.tick(4);
    @(negedge clk);
    prev = divided_ring_clock;
    repeat (16) begin
      @(negedge clk);
      n += int'(divided_ring_clock !== prev);
      prev = divided_ring_clock;
    end
    chk(16'(n), 16'h0008);
    @(posedge clk);
    $display("test oscillator done");
  endtask
  // erased read, write, read back; first write re-strobed while busy
  task automatic t_write;
    logic [8:0]  a[3] = '{9'h000, 9'h100, 9'h1ff};
    logic [15:0] d[3] = '{16'h1234, 16'h5a0f, 16'hc3a5};
    for (int i = 0; i < 3; i++) begin
      rd(a[i], 16'hffff);
      ctl.data_write(d[i]);
      run_seq(1'b1, 24, i == 0);
      ctl.data_read(q);
      chk(q, d[i]);
    end
    $display("test write done");
  endtask
  task automatic t_wrap;
    rd(9'h1ff, 16'hc3a5);
    ctl.addr_inc();
    ctl.data_read(q);
    chk(q, 16'h1234);
    ctl.addr_inc();
    ctl.data_read(q);
    chk(q, 16'hffff);
    $display("test wrap done");
  endtask
  task automatic t_erase;
    ctl.addr_load(9'h180);
    run_seq(1'b0, 40, 1'b0);
    rd(9'h100, 16'hffff);
    rd(9'h1ff, 16'hffff);
    rd(9'h000, 16'h1234);
    $display("test erase done");
  endtask
  // ce low freezes the divider and swallows a whole address clock pulse
  task automatic t_ce;
    logic v;
    rd(9'h000, 16'h1234);
    ce <= 1'b0;
    ctl.tick(2);
    v = divided_ring_clock;
    ctl.addr_inc();
    ctl.tick(4);
    chk(16'(divided_ring_clock), 16'(v));
    ce <= 1'b1;
    ctl.tick(2);
    ctl.data_read(q);
    chk(q, 16'h1234);
    $display("test clock enable done");
  endtask
  // reset in mid-run: data out and busy drop, divided clock goes high, words stay, address returns to zero
  task automatic t_reset;
    ctl.addr_load(9'h0ff);
    resetn <= 1'b0;
    ctl.tick(3);
    chk({data_serial_out, busy, divided_ring_clock}, 16'h0001);
    resetn <= 1'b1;
    ctl.tick(2);
    ctl.data_read(q);
    chk(q, 16'h1234);
    $display("test reset done");
  endtask
  // strobe under live reprogram is refused
  task automatic t_live;
    live_reprogram_request <= 1'b1;
    ctl.tick(2);
    chk(16'(live_reprogram_active), 16'h0001);
    ctl.strobe(1'b1, 1'b1);
    ctl.tick(15);
    chk(16'(busy), 16'h0000);
    ctl.strobe(1'b1, 1'b0);
    live_reprogram_request <= 1'b0;
    ctl.tick(4);
    $display("test live done");
  endtask
  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    chk({data_serial_out, busy, divided_ring_clock}, 16'h0001);
    resetn <= 1'b1;
    t_osc();
    t_write();
    t_wrap();
    t_erase();
    t_ce();
    t_reset();
    t_live();
    end_of_test();
  end
  initial begin
    #(60000 * 100);
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
